// *** sdl_diag_core.sv ***
// module: fault classification, safe-state forcing and indicator leds
//
// Function
// - missing or faulty project: module state led flashes red at 1 Hz
// - configuration error: stop apps, outputs off, safe data zero
// - repairable error: apps run; affected red/green 1 Hz, else green
// - repairable error: switch off affected outputs, zero affected inputs
// - critical: stop all, clear all; detector 2 Hz red, others red
// - critical state held until power-on reset; supply off three seconds
// - control error: 24 V outputs off, red pulse groups of error class
// - class counts: 2 config to 8 internal, as listed
// - power led flashes green 1 Hz on bad supply, steady otherwise, green off in control error
// - project adopted: green 1 Hz until start, then steady green
// - cable break, short, two-channel or output test error: red/green
// - unverified: code led yellow 1 Hz, no automatic start
// - verified: code led steady yellow, automatic start after reset
// - connection setup: link led flashes green for 3 s
// - single-channel test error: input led 1 Hz, in red phase
// - unconfigured input at 24 V: input led flashes green 1 Hz
// - two-channel input error: the pair flashes alternately at 1 Hz
// - no error: input led follows input level, off or green
`timescale 1ns/1ps
module sdl_diag_core (
    clk,
    rst_n,
    project_missing,
    project_faulty,
    project_adopted,
    project_verified,
    start_cmd,
    ctrl_fault,
    critical_here,
    critical_other,
    supply_bad,
    link_setup,
    out_fault,
    out_request,
    in_level,
    in_configured,
    in_two_channel,
    in_test_err,
    pair_err,
    out_enable,
    in_safe_data,
    app_run,
    module_state_indicator,
    power_error_class_indicator,
    code_verified_indicator,
    link_activity_indicator,
    input_indicator
);
    localparam int N = sdl_pkg::NUM_INPUTS;
    localparam int P = sdl_pkg::NUM_INPUTS / 2;
    input wire logic clk;
    input wire logic rst_n;
    input wire logic project_missing;
    input wire logic project_faulty;
    input wire logic project_adopted;
    input wire logic project_verified;
    input wire logic start_cmd;
    input wire sdl_pkg::sdl_ctrl_fault_t ctrl_fault;
    input wire logic critical_here;
    input wire logic critical_other;
    input wire logic supply_bad;
    input wire logic link_setup;
    input wire logic [3:0] out_fault;
    input wire logic [3:0] out_request;
    input wire logic [N-1:0] in_level;
    input wire logic [N-1:0] in_configured;
    input wire logic [P-1:0] in_two_channel;
    input wire logic [N-1:0] in_test_err;
    input wire logic [P-1:0] pair_err;
    output logic [3:0] out_enable;
    output logic [N-1:0] in_safe_data;
    output logic app_run;
    output sdl_pkg::sdl_led_t module_state_indicator;
    output sdl_pkg::sdl_led_t power_error_class_indicator;
    output logic code_verified_indicator;
    output logic link_activity_indicator;
    output logic [N-1:0] input_indicator;

    typedef enum logic [2:0] {
        SDL_CONFIG,
        SDL_STOPPED,
        SDL_RUNNING,
        SDL_CRITICAL,
        SDL_CTRL_ERR
    } sdl_state_t;

    sdl_state_t state_q;
    sdl_state_t state_d;
    logic critical_local_q;
    logic [3:0] ec_count_q;
    logic [24:0] slow_cnt_q;
    logic [24:0] fast_cnt_q;
    logic [22:0] ec_cnt_q;
    logic slow_ph_q;
    logic fast_ph_q;
    logic ec_tick;
    logic [27:0] net_cnt_q;
    logic setup_prev_q;
    logic auto_start_q;
    logic boot_q;
    logic ec_led;

    ////////////////////////////////////////////////////////////////////////
    // timebases

    wire slow_wrap = slow_cnt_q == 25'(sdl_pkg::SLOW_HALF_CYC - 1);
    wire fast_wrap = fast_cnt_q == 25'(sdl_pkg::FAST_HALF_CYC - 1);
    assign ec_tick = ec_cnt_q == 23'(sdl_pkg::EC_TICK_CYC - 1);

    // half-period counters; slow phase high is the red phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt_q <= 25'h0000000;
            fast_cnt_q <= 25'h0000000;
            ec_cnt_q <= 23'h000000;
            slow_ph_q <= 1'b0;
            fast_ph_q <= 1'b0;
        end else begin
            slow_cnt_q <= slow_wrap ? 25'h0000000 : slow_cnt_q + 25'h0000001;
            fast_cnt_q <= fast_wrap ? 25'h0000000 : fast_cnt_q + 25'h0000001;
            ec_cnt_q <= ec_tick ? 23'h000000 : ec_cnt_q + 23'h000001;
            slow_ph_q <= slow_ph_q ^ slow_wrap;
            fast_ph_q <= fast_ph_q ^ fast_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault classification

    wire config_err = project_missing || project_faulty;
    wire ctrl_any = |ctrl_fault;
    wire critical_any = critical_here || critical_other;
    // error class, lowest source wins
    wire [3:0] ec_sel = ctrl_fault.config_data ? sdl_pkg::EC_CONFIG :
        ctrl_fault.application ? sdl_pkg::EC_APPLICATION :
        ctrl_fault.self_test ? sdl_pkg::EC_SELF_TEST :
        ctrl_fault.supply_mon ? sdl_pkg::EC_SUPPLY_MON :
        ctrl_fault.io_modules ? sdl_pkg::EC_IO_MODULES :
        ctrl_fault.cross_comm ? sdl_pkg::EC_CROSS_COMM :
        sdl_pkg::EC_INTERNAL;
    // per-pair and per-input repairable errors
    logic [N-1:0] single_err;
    logic [N-1:0] pair_flag;
    logic [N-1:0] unconf_hot;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_in
            assign pair_flag[g] = in_two_channel[g/2] &&
                (pair_err[g/2] || in_test_err[g & ~1] ||
                 in_test_err[g | 1]);
            assign single_err[g] = !in_two_channel[g/2] && in_configured[g]
                && in_test_err[g];
            assign unconf_hot[g] = !in_configured[g] && in_level[g];
        end
    endgenerate
    wire repair_err = (|single_err) || (|pair_flag) || (|out_fault);

    ////////////////////////////////////////////////////////////////////////
    // state machine

    // critical and control errors are terminal until power-on reset
    always_comb begin
        state_d = state_q;
        case (state_q)
            SDL_CRITICAL: state_d = SDL_CRITICAL;
            SDL_CTRL_ERR: state_d = SDL_CTRL_ERR;
            default: begin
                if (critical_any) begin
                    state_d = SDL_CRITICAL;
                end else if (ctrl_any) begin
                    state_d = SDL_CTRL_ERR;
                end else if (config_err || !project_adopted) begin
                    state_d = SDL_CONFIG;
                end else if (state_q == SDL_RUNNING) begin
                    state_d = SDL_RUNNING;
                end else if (start_cmd || auto_start_q) begin
                    state_d = SDL_RUNNING;
                end else begin
                    state_d = SDL_STOPPED;
                end
            end
        endcase
    end

    // state, latched fault details, auto-start strap taken after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SDL_CONFIG;
            critical_local_q <= 1'b0;
            ec_count_q <= 4'h0;
            boot_q <= 1'b1;
            auto_start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            boot_q <= 1'b0;
            if (boot_q) begin
                auto_start_q <= project_verified;
            end else if (state_q == SDL_RUNNING) begin
                auto_start_q <= 1'b0;
            end
            if (state_q != SDL_CRITICAL && critical_here) begin
                critical_local_q <= 1'b1;
            end
            if (state_q != SDL_CTRL_ERR && ctrl_any) begin
                ec_count_q <= ec_sel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // safe-state forcing

    wire running = state_q == SDL_RUNNING;
    wire [3:0] out_en_d = running ? (out_request & ~out_fault) : 4'h0;
    wire [N-1:0] safe_d = running ?
        (in_level & in_configured & ~single_err & ~pair_flag) : '0;

    // outputs forced off and safe data zero outside running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_enable <= 4'h0;
            in_safe_data <= '0;
            app_run <= 1'b0;
        end else begin
            out_enable <= out_en_d;
            in_safe_data <= safe_d;
            app_run <= running;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators

    sdl_ec_blinker u_ec (
        .clk(clk),
        .rst_n(rst_n),
        .tick(ec_tick),
        .count(ec_count_q),
        .enable(state_q == SDL_CTRL_ERR),
        .led(ec_led)
    );

    // module state led selection
    sdl_pkg::sdl_led_t ms_d;
    always_comb begin
        ms_d = '0;
        case (state_q)
            SDL_CONFIG: ms_d.red = slow_ph_q;
            SDL_STOPPED: ms_d.green = slow_ph_q;
            SDL_RUNNING: begin
                ms_d.red = repair_err && slow_ph_q;
                ms_d.green = repair_err ? !slow_ph_q : 1'b1;
            end
            SDL_CRITICAL: ms_d.red = critical_local_q ? fast_ph_q : 1'b1;
            SDL_CTRL_ERR: ms_d.red = 1'b1;
            default: ms_d = '0;
        endcase
    end

    // power led: control error pulses beat supply indication
    sdl_pkg::sdl_led_t pw_d;
    assign pw_d.red = state_q == SDL_CTRL_ERR && ec_led;
    assign pw_d.green = state_q != SDL_CTRL_ERR &&
        (supply_bad ? slow_ph_q : 1'b1);

    // input leds
    logic [N-1:0] in_led_d;
    generate
        for (g = 0; g < N; g++) begin : g_led
            assign in_led_d[g] = pair_flag[g] ?
                (slow_ph_q ^ 1'(g % 2)) :
                (single_err[g] || unconf_hot[g]) ?
                slow_ph_q :
                in_level[g];
        end
    endgenerate

    // link setup window restarts on each rising edge of setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            net_cnt_q <= 28'h0000000;
            setup_prev_q <= 1'b0;
        end else begin
            setup_prev_q <= link_setup;
            if (link_setup && !setup_prev_q) begin
                net_cnt_q <= 28'(sdl_pkg::NET_SETUP_CYC);
            end else if (net_cnt_q != 28'h0000000) begin
                net_cnt_q <= net_cnt_q - 28'h0000001;
            end
        end
    end

    // indicator registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_state_indicator <= '0;
            power_error_class_indicator <= '0;
            code_verified_indicator <= 1'b0;
            link_activity_indicator <= 1'b0;
            input_indicator <= '0;
        end else begin
            module_state_indicator <= ms_d;
            power_error_class_indicator <= pw_d;
            code_verified_indicator <= project_verified ? 1'b1 :
                slow_ph_q;
            link_activity_indicator <= (net_cnt_q != 28'h0000000) &&
                slow_ph_q;
            input_indicator <= in_led_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_critical_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_CRITICAL |=> state_q == SDL_CRITICAL)
        else $error("critical state left without reset");
    a_config_safe: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_CONFIG |=> out_enable == 4'h0 && !app_run)
        else $error("outputs on in configuration state");
    a_critical_off: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_CRITICAL |=> in_safe_data == '0)
        else $error("safe data not cleared on critical error");
    a_ctrl_red: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_CTRL_ERR |=> out_enable == 4'h0 &&
        !power_error_class_indicator.green)
        else $error("control error indication wrong");
    a_fault_out_off: assert property (@(posedge clk) disable iff (!rst_n)
        (out_fault[0]) |=> !out_enable[0])
        else $error("faulty output left on");
    a_running_led: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_RUNNING && !repair_err |=>
        module_state_indicator == 2'b01)
        else $error("running without steady green");
    a_critical_other: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SDL_CRITICAL && !critical_local_q |=>
        module_state_indicator == 2'b10)
        else $error("foreign critical not steady red");
    a_net_window: assert property (@(posedge clk) disable iff (!rst_n)
        (link_setup && !setup_prev_q) |=> net_cnt_q != 28'h0000000)
        else $error("link setup window not started");
    a_supply_ok: assert property (@(posedge clk) disable iff (!rst_n)
        !supply_bad && state_q != SDL_CTRL_ERR |=>
        power_error_class_indicator.green)
        else $error("power led not steady with good supply");
    a_verified_cv: assert property (@(posedge clk) disable iff (!rst_n)
        project_verified |=> code_verified_indicator)
        else $error("verified project not steady yellow");
    c_running: cover property (@(posedge clk) state_q == SDL_RUNNING);
    c_critical: cover property (@(posedge clk) state_q == SDL_CRITICAL);
    c_ctrl_err: cover property (@(posedge clk) state_q == SDL_CTRL_ERR);
endmodule

// *** sdl_ec_blinker.sv ***
// module: pulse-group generator for the error class indicator
`timescale 1ns/1ps
module sdl_ec_blinker (
    clk,
    rst_n,
    tick,
    count,
    enable,
    led
);
    input wire logic clk;
    input wire logic rst_n;
    input wire logic tick;
    input wire logic [3:0] count;
    input wire logic enable;
    output logic led;

    logic [4:0] phase_q;
    logic [4:0] phase_d;
    logic [4:0] group_len;
    logic led_d;

    // group: count pulses of two ticks each, then a long pause
    assign group_len = {count, 1'b0} + 5'(sdl_pkg::EC_PAUSE_TICKS);
    assign phase_d = (phase_q + 5'h01 >= group_len) ? 5'h00 : phase_q + 5'h01;
    assign led_d = enable && (phase_q < {count, 1'b0}) && !phase_q[0];

    // phase walks on tick, restarts when disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 5'h00;
        end else if (!enable) begin
            phase_q <= 5'h00;
        end else if (tick) begin
            phase_q <= phase_d;
        end
    end

    // led register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led <= 1'b0;
        end else begin
            led <= led_d;
        end
    end

    a_pause_length: assert property (@(posedge clk) disable iff (!rst_n)
        (enable && tick && phase_q == {count, 1'b0}) |=> !led [*8])
        else $error("error class pause too short");
endmodule

// *** sdl_field_model.sv ***
// field side model: sensors, combined channel readback, short reports
`timescale 1ns/1ps
module sdl_field_model (
    sensor,
    short_cmd,
    out_enable,
    in_level,
    out_fault
);
    input wire logic [19:0] sensor;
    input wire logic [3:0] short_cmd;
    input wire logic [3:0] out_enable;
    output logic [19:0] in_level;
    output logic [3:0] out_fault;
    ////////////////////////////////////////////////////////////////////////
    // combined channels read their own driven output back as input level
    assign in_level = sensor | {out_enable, 16'h0};
    // output supervisor reports a short for as long as it stands
    assign out_fault = short_cmd;
endmodule

// *** sdl_pkg.sv ***
// package: shared types and timing constants of the diagnostic led block
package sdl_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // blink rates and periods, in their own units
    localparam int unsigned SLOW_BLINK_HZ = 1;
    localparam int unsigned FAST_BLINK_HZ = 2;
    localparam int unsigned NET_SETUP_S = 3;
    // half periods and setup window in clock cycles
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
    localparam int unsigned NET_SETUP_CYC = CLK_HZ * NET_SETUP_S;
    // error class pulse train: pulse on/off tick count, pause between groups
    localparam int unsigned EC_PULSE_HZ = 4;
    localparam int unsigned EC_TICK_CYC = CLK_HZ / (2 * EC_PULSE_HZ);
    localparam int unsigned EC_PAUSE_TICKS = 8;
    localparam int unsigned NUM_INPUTS = 20;
    // error class pulse counts
    localparam logic [3:0] EC_CONFIG = 4'h2;
    localparam logic [3:0] EC_APPLICATION = 4'h3;
    localparam logic [3:0] EC_SELF_TEST = 4'h4;
    localparam logic [3:0] EC_SUPPLY_MON = 4'h5;
    localparam logic [3:0] EC_IO_MODULES = 4'h6;
    localparam logic [3:0] EC_CROSS_COMM = 4'h7;
    localparam logic [3:0] EC_INTERNAL = 4'h8;
    // one-hot control fault sources, lowest index wins
    typedef struct packed {
        logic internal;
        logic cross_comm;
        logic io_modules;
        logic supply_mon;
        logic self_test;
        logic application;
        logic config_data;
    } sdl_ctrl_fault_t;
    // bicolour indicator drive
    typedef struct packed {
        logic red;
        logic green;
    } sdl_led_t;
endpackage

// *** sdl_testbench.sv ***
// self-checking bench for the diagnostic core and the class blinker
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [3:0] req;
        logic [3:0] shrt;
        logic [19:0] sens;
        logic [19:0] cfg;
        logic [19:0] terr;
        logic [9:0] two;
        logic [9:0] perr;
    } sdl_row_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic project_missing = 1'h0, project_faulty = 1'h0;
    logic project_adopted = 1'h0, project_verified = 1'h0, start_cmd = 1'h0;
    logic critical_here = 1'h0, critical_other = 1'h0;
    sdl_pkg::sdl_ctrl_fault_t ctrl_fault = '0;
    logic [3:0] out_request = 4'h0, short_cmd = 4'h0, out_fault, out_enable;
    logic [19:0] sensor = 20'h0, in_configured = 20'h0, in_test_err = 20'h0;
    logic [19:0] in_level, in_safe_data, input_indicator;
    logic [9:0] in_two_channel = 10'h0, pair_err = 10'h0;
    logic app_run, code_verified_indicator, link_activity_indicator;
    sdl_pkg::sdl_led_t module_state_indicator, power_error_class_indicator;
    logic supply_bad = 1'h0, link_setup = 1'h0;
    int n_mismatch = 0, total_checks = 0;
    sdl_row_t rows[6];
    logic [3:0] codes[7];
    ////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #12.5 clk = ~clk;
    sdl_diag_core uut (.clk(clk), .rst_n(rst_n),
        .project_missing(project_missing), .project_faulty(project_faulty),
        .project_adopted(project_adopted),
        .project_verified(project_verified), .start_cmd(start_cmd),
        .ctrl_fault(ctrl_fault), .critical_here(critical_here),
        .critical_other(critical_other), .supply_bad(supply_bad),
        .link_setup(link_setup), .out_fault(out_fault),
        .out_request(out_request),
        .in_level(in_level), .in_configured(in_configured),
        .in_two_channel(in_two_channel), .in_test_err(in_test_err),
        .pair_err(pair_err), .out_enable(out_enable),
        .in_safe_data(in_safe_data), .app_run(app_run),
        .module_state_indicator(module_state_indicator),
        .power_error_class_indicator(power_error_class_indicator),
        .code_verified_indicator(code_verified_indicator),
        .link_activity_indicator(link_activity_indicator),
        .input_indicator(input_indicator));
    sdl_field_model field (.sensor(sensor), .short_cmd(short_cmd),
        .out_enable(out_enable), .in_level(in_level), .out_fault(out_fault));
    ////////////////////////////////////////////////////////////////////////
    // comparison, closing report and timing helpers
    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // power cycle: supply removed, project, critical and control sources cleared, project adopted
    task power_cycle(input logic verified);
        @(posedge clk);
        rst_n <= 1'h0;
        project_verified <= verified;
        project_adopted <= 1'h1;
        {project_missing, project_faulty, start_cmd} <= 3'h0;
        {critical_here, critical_other} <= 2'h0;
        ctrl_fault <= '0;
        settle(5);
        check("app_run_in_reset", app_run, 1'h0);
        check("out_enable_in_reset", out_enable, 4'h0);
        @(posedge clk);
        rst_n <= 1'h1;
    endtask
    // one table row: apply stimulus, derive and compare expected outputs
    task run_row(input sdl_row_t r);
        logic [3:0] en;
        logic [19:0] lvl, pm;
        int k;
        en = r.req & ~r.shrt;
        lvl = r.sens | {en, 16'h0};
        for (k = 0; k < 10; k++) begin
            pm[2*k] = r.perr[k];
            pm[2*k+1] = r.perr[k];
        end
        @(posedge clk);
        out_request <= r.req;
        short_cmd <= r.shrt;
        sensor <= r.sens;
        in_configured <= r.cfg;
        in_test_err <= r.terr;
        in_two_channel <= r.two;
        pair_err <= r.perr;
        settle(6);
        check("out_enable", out_enable, en);
        check("in_safe_data", in_safe_data, lvl & r.cfg & ~r.terr & ~pm);
        check("app_run", app_run, 1'h1);
        check("power_led", power_error_class_indicator, 2'h1);
        if (r.terr == 0 && r.perr == 0 && (lvl & ~r.cfg) == 0)
            check("input_led", input_indicator, lvl);
        if (r.shrt == 0 && r.terr == 0 && r.perr == 0)
            check("ms_led", module_state_indicator, 2'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("ERROR run_time expected finish seen timeout");
        wrap_up;
    end
    // main sequence
    initial begin
        int i;
        rows[0] = '{4'h0, 4'h0, 20'h00000, 20'hfffff, 20'h0, 10'h0, 10'h0};
        rows[1] = '{4'hf, 4'h0, 20'h0a5c3, 20'hfffff, 20'h0, 10'h0, 10'h0};
        rows[2] = '{4'h0, 4'h0, 20'h00f0f, 20'h0ff0f, 20'h0, 10'h0, 10'h0};
        rows[3] = '{4'hf, 4'h2, 20'h00001, 20'hfffff, 20'h0, 10'h0, 10'h0};
        rows[4] = '{4'h3, 4'h0, 20'h000ff, 20'hfffff, 20'h8, 10'h0, 10'h0};
        rows[5] = '{4'h0, 4'h0, 20'h000f0, 20'hfffff, 20'h0, 10'h4, 10'h4};
        codes = '{sdl_pkg::EC_CONFIG, sdl_pkg::EC_APPLICATION,
                  sdl_pkg::EC_SELF_TEST, sdl_pkg::EC_SUPPLY_MON,
                  sdl_pkg::EC_IO_MODULES, sdl_pkg::EC_CROSS_COMM,
                  sdl_pkg::EC_INTERNAL};
        power_cycle(1'h1);
        for (i = 0; i < 20 && app_run !== 1'h1; i++) settle(1);
        check("auto_start", app_run, 1'h1);
        check("cv_led", code_verified_indicator, 1'h1);
        $display("test auto start done");
        for (i = 0; i < 6; i++) run_row(rows[i]);
        $display("test row table done");
        run_row(rows[1]);
        @(posedge clk);
        project_faulty <= 1'h1;
        settle(4);
        check("cfg_app_run", app_run, 1'h0);
        check("cfg_out_enable", out_enable, 4'h0);
        check("cfg_safe_data", in_safe_data, 20'h0);
        $display("test configuration error done");
        power_cycle(1'h0);
        settle(8);
        check("no_auto_start", app_run, 1'h0);
        @(posedge clk);
        start_cmd <= 1'h1;
        settle(4);
        check("started", app_run, 1'h1);
        check("ms_running", module_state_indicator, 2'h1);
        check("cv_unverified", code_verified_indicator, 1'h0);
        $display("test start command done");
        @(posedge clk);
        supply_bad <= 1'h1;
        link_setup <= 1'h1;
        settle(4);
        check("pw_flash", power_error_class_indicator, 2'h0);
        check("net_window", uut.net_cnt_q != 28'h0, 1'h1);
        check("net_led", link_activity_indicator, 1'h0);
        @(posedge clk);
        supply_bad <= 1'h0;
        settle(3);
        check("pw_steady", power_error_class_indicator, 2'h1);
        $display("test supply and link done");
        power_cycle(1'h1);
        @(posedge clk);
        project_missing <= 1'h1;
        settle(6);
        check("missing_app_run", app_run, 1'h0);
        $display("test missing project done");
        for (i = 0; i < 7; i++) begin
            power_cycle(1'h1);
            run_row(rows[1]);
            @(posedge clk);
            ctrl_fault <= sdl_pkg::sdl_ctrl_fault_t'(7'h1 << i);
            settle(4);
            check("ctrl_app_run", app_run, 1'h0);
            check("ctrl_out_enable", out_enable, 4'h0);
            check("ctrl_ms_led", module_state_indicator, 2'h2);
            check("ctrl_pw_led", power_error_class_indicator, 2'h2);
            check("ctrl_class", uut.ec_count_q, codes[i]);
            @(posedge clk);
            ctrl_fault <= '0;
            settle(4);
            check("ctrl_latched", app_run, 1'h0);
        end
        $display("test control errors done");
        for (i = 0; i < 2; i++) begin
            power_cycle(1'h1);
            run_row(rows[1]);
            @(posedge clk);
            critical_here <= (i == 0);
            critical_other <= (i == 1);
            settle(4);
            check("crit_app_run", app_run, 1'h0);
            check("crit_out_enable", out_enable, 4'h0);
            check("crit_safe_data", in_safe_data, 20'h0);
            if (i == 1)
                check("crit_ms_led", module_state_indicator, 2'h2);
            @(posedge clk);
            {critical_here, critical_other} <= 2'h0;
            settle(4);
            check("crit_latched", app_run, 1'h0);
        end
        power_cycle(1'h1);
        settle(6);
        check("restart_after_reset", app_run, 1'h1);
        $display("test critical errors done");
        wrap_up;
    end
endmodule
